// File: rtl/cmps_regs.vh
// constants of the control mode strap select block: register map, fields, timing
// assumes inclusion by bare name from the block's design files
`ifndef CMPS_REGS_VH
`define CMPS_REGS_VH
// register byte offsets
`define CMPS_CTRL_OFS 12'h000
`define CMPS_STATUS_OFS 12'h004
`define CMPS_CONFIG_OFS 12'h008
`define CMPS_USER0_OFS 12'h00C
`define CMPS_USER1_OFS 12'h010
`define CMPS_USER2_OFS 12'h014
// control fields
`define CMPS_CTRL_RESAMPLE 0
// config fields, also the layout of user register 0
`define CMPS_CFG_SWING 0
`define CMPS_CFG_EDGE 1
`define CMPS_CFG_DDR 2
`define CMPS_CFG_CAL_DELAY 3
`define CMPS_CFG_FSR 4
// user register widths and reset values
`define CMPS_USER_W 16
`define CMPS_USER_NUM 3
`define CMPS_USER0_RST 16'h0013
`define CMPS_USER1_RST 16'h0000
`define CMPS_USER2_RST 16'h0000
// serial frame: 2 address bits then 16 data bits, msb first
`define CMPS_FRAME_BITS 5'd18
// cycles after reset release before the straps are taken
`define CMPS_SETTLE_CYC 4'd4
`endif

// File: rtl/cmps_sync.v
// two flip-flop synchroniser for a group of pin levels
// assumes asynchronous inputs; output is stable in the hclk domain
`default_nettype none
module cmps_sync #(
  parameter W = 6
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // levels
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  // first stage feeds only the second stage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule
`default_nettype wire

// File: rtl/cmps_top.v
// control mode strap select: three-level strap decode, serial port, ahb-lite registers
// assumes pins come from outside the hclk domain; tri-level pins arrive as level plus float
//
// Summary of operation
// - mode pin high or low: serial port off, all functions from pin levels
// - pin mode: mode pin low gives reduced input range, high gives normal range
// - mode pin floating: extended mode, swing/edge/delay pins become serial clock/data/select
// - pin mode: swing pin low reduced amplitude, high normal amplitude
// - pin mode: edge pin low launches on falling edge, high on rising edge
// - pin mode: floating edge pin selects double data rate output clock
// - double data rate launches on both edges; edge choice ignored
// - pin mode: delay pin low short calibration delay, high long delay
// - after all initial writes, later register writes are still accepted
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`default_nettype none
`include "cmps_regs.vh"
module cmps_top (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // strap pins, tri-level ones split into level and float sense
  input wire mode_pin_level,
  input wire mode_pin_float,
  input wire swing_pin,
  input wire edge_pin_level,
  input wire edge_pin_float,
  input wire delay_pin,
  // decoded configuration
  output reg output_swing_level,
  output reg output_launch_edge,
  output reg ddr_enable,
  output reg calibration_delay_select,
  output reg input_full_scale_range,
  output reg serial_enable,
  output reg cal_permit,
  output reg [15:0] user_reg0,
  output reg [15:0] user_reg1,
  output reg [15:0] user_reg2
);
  wire [5:0] pins_s;
  reg [3:0] settle_q;
  reg strap_done_q;
  reg ext_mode_q;
  reg mode_lvl_q;
  reg swing_q;
  reg edge_lvl_q;
  reg edge_flt_q;
  reg cal_delay_q;
  reg resample_q;
  reg wr_pend_q;
  reg [11:0] addr_q;
  reg sclk_prev_q;
  reg cs_prev_q;
  reg [17:0] shift_q;
  reg [4:0] bit_cnt_q;
  reg [2:0] written_q;
  reg [7:0] err_cnt_q;
  wire sclk_s;
  wire ser_data_s;
  wire cs_n_s;
  wire sclk_rise;
  wire cs_rise;
  wire cs_fall;
  wire frame_ok;
  wire [4:0] cfg_bits;

  // every pin is synchronised before any logic looks at it
  cmps_sync #(.W(6)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({mode_pin_level, mode_pin_float, swing_pin, edge_pin_level,
               edge_pin_float, delay_pin}),
    .sync_out(pins_s)
  );

  // serial roles of the reassigned pins
  assign sclk_s = pins_s[3];
  assign ser_data_s = pins_s[2];
  assign cs_n_s = pins_s[0];

  // straps taken once the synchroniser has filled after reset, then held until software asks for a resample
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_q <= 4'h0;
      strap_done_q <= 1'b0;
      ext_mode_q <= 1'b0;
      mode_lvl_q <= 1'b0;
      swing_q <= 1'b0;
      edge_lvl_q <= 1'b0;
      edge_flt_q <= 1'b0;
      cal_delay_q <= 1'b0;
    end else if (resample_q) begin
      settle_q <= 4'h0;                      // software may ask for a new look
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (settle_q == `CMPS_SETTLE_CYC) begin
        strap_done_q <= 1'b1;
        ext_mode_q <= pins_s[4];
        mode_lvl_q <= pins_s[5];
        swing_q <= pins_s[3];
        edge_lvl_q <= pins_s[2];
        edge_flt_q <= pins_s[1];
        cal_delay_q <= pins_s[0];            // level assumed driven
      end else begin
        settle_q <= settle_q + 4'h1;
      end
    end
  end

  // edge detection on synchronised serial pins; only live in extended mode
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end
  assign sclk_rise = serial_enable & sclk_s & ~sclk_prev_q;
  assign cs_fall = serial_enable & ~cs_n_s & cs_prev_q;
  assign cs_rise = serial_enable & cs_n_s & ~cs_prev_q;
  assign frame_ok = (bit_cnt_q == `CMPS_FRAME_BITS) && (shift_q[17:16] != 2'b11);

  // serial shifter; a frame of the wrong length or address is dropped and counted
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q <= 18'h0_0000;
      bit_cnt_q <= 5'h00;
      written_q <= 3'b000;
      err_cnt_q <= 8'h00;
      user_reg0 <= `CMPS_USER0_RST;
      user_reg1 <= `CMPS_USER1_RST;
      user_reg2 <= `CMPS_USER2_RST;
    end else begin
      if (cs_fall) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_rise && !cs_n_s) begin
        shift_q <= {shift_q[16:0], ser_data_s};
        if (bit_cnt_q != 5'h1f) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end
      if (cs_rise) begin
        if (frame_ok) begin
          // writes are taken every time, first or later
          case (shift_q[17:16])
            2'b00: user_reg0 <= shift_q[15:0];
            2'b01: user_reg1 <= shift_q[15:0];
            default: user_reg2 <= shift_q[15:0];
          endcase
          written_q[shift_q[17:16]] <= 1'b1;
        end else if (err_cnt_q != 8'hff) begin
          err_cnt_q <= err_cnt_q + 8'h01;
        end
      end
    end
  end

  // serial-side view of the functions, taken from user register 0
  assign cfg_bits = user_reg0[4:0];

  // decoded outputs; pin mode follows the held straps, extended mode the user register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_swing_level <= 1'b0;
      output_launch_edge <= 1'b0;
      ddr_enable <= 1'b0;
      calibration_delay_select <= 1'b0;
      input_full_scale_range <= 1'b0;
      serial_enable <= 1'b0;
      cal_permit <= 1'b0;
    end else if (!strap_done_q) begin
      serial_enable <= 1'b0;
      cal_permit <= 1'b0;
    end else if (ext_mode_q) begin
      serial_enable <= 1'b1;
      output_swing_level <= cfg_bits[`CMPS_CFG_SWING];
      ddr_enable <= cfg_bits[`CMPS_CFG_DDR];
      output_launch_edge <= cfg_bits[`CMPS_CFG_DDR] ? 1'b0 : cfg_bits[`CMPS_CFG_EDGE];
      calibration_delay_select <= cfg_bits[`CMPS_CFG_CAL_DELAY];
      input_full_scale_range <= cfg_bits[`CMPS_CFG_FSR];
      cal_permit <= &written_q;
    end else begin
      serial_enable <= 1'b0;
      output_swing_level <= swing_q;
      ddr_enable <= edge_flt_q;
      output_launch_edge <= edge_flt_q ? 1'b0 : edge_lvl_q;
      calibration_delay_select <= cal_delay_q;
      input_full_scale_range <= mode_lvl_q;
      cal_permit <= 1'b1;
    end
  end

  // ahb-lite: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture; the write lands in the following data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
      resample_q <= 1'b0;
    end else begin
      resample_q <= wr_pend_q && (addr_q == `CMPS_CTRL_OFS) && hwdata[`CMPS_CTRL_RESAMPLE];
      wr_pend_q <= hsel & hready & htrans[1] & hwrite;
      if (hsel & hready & htrans[1]) begin
        addr_q <= haddr;
      end
    end
  end

  // read data registered at the address phase so it stands in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel & hready & htrans[1] & ~hwrite) begin
      case (haddr)
        `CMPS_STATUS_OFS: hrdata <= {16'h0000, err_cnt_q, 2'b00, serial_enable, cal_permit,
                                     written_q, strap_done_q};
        `CMPS_CONFIG_OFS: hrdata <= {27'h000_0000, input_full_scale_range,
                                     calibration_delay_select, ddr_enable,
                                     output_launch_edge, output_swing_level};
        `CMPS_USER0_OFS: hrdata <= {16'h0000, user_reg0};
        `CMPS_USER1_OFS: hrdata <= {16'h0000, user_reg1};
        `CMPS_USER2_OFS: hrdata <= {16'h0000, user_reg2};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: bench/cmps_top_assertions.sv
// checker of the strap select block, sees only cmps_top ports
// assumes one hclk domain with hresetn as its reset
`default_nettype none
module cmps_top_assertions (
  input wire hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cal_permit,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire [31:0] hrdata,
  input wire output_swing_level, output_launch_edge, ddr_enable, serial_enable,
  input wire calibration_delay_select, input_full_scale_range,
  input wire [15:0] user_reg0, user_reg1, user_reg2
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire [4:0] cfg = {input_full_scale_range, calibration_delay_select, ddr_enable,
    output_launch_edge, output_swing_level};
  logic [3:0] quiet_q;
  // a resample needs bus traffic, so a long quiet spell means settled straps
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) quiet_q <= 4'h0;
    else if (hsel) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  a_ddr_edge_low: assert property (
    ddr_enable |-> !output_launch_edge) else $error("edge set in ddr");
  a_pin_serial_off: assert property (
    !serial_enable && !$past(serial_enable) |-> $stable({user_reg0, user_reg1, user_reg2}))
    else $error("user register moved in pin mode");
  a_ext_user_cfg: assert property (
    serial_enable && $past(serial_enable) && $stable(user_reg0) |->
    cfg == {user_reg0[4:2], user_reg0[1] & !user_reg0[2], user_reg0[0]})
    else $error("config differs from user register 0");
  a_strap_held: assert property (
    quiet_q == 4'hf && !serial_enable && cal_permit && $past(cal_permit, 2) |-> $stable(cfg))
    else $error("config moved while straps held");
  a_cfg_read: assert property (
    s_rd ##0 haddr == 12'h008 |=> hrdata[4:0] == $past(cfg)) else $error("config read");
  a_unmapped_zero: assert property (
    s_rd ##0 haddr > 12'h014 |=> hrdata == 32'h0000_0000) else $error("unmapped read");
  a_upper_zero: assert property (
    hrdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_okay_resp: assert property (
    hreadyout && !hresp) else $error("wait or error response");
endmodule
bind cmps_top cmps_top_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .cal_permit(cal_permit), .haddr(haddr), .htrans(htrans), .hrdata(hrdata),
  .output_swing_level(output_swing_level), .output_launch_edge(output_launch_edge),
  .ddr_enable(ddr_enable), .serial_enable(serial_enable),
  .calibration_delay_select(calibration_delay_select),
  .input_full_scale_range(input_full_scale_range), .user_reg0(user_reg0),
  .user_reg1(user_reg1), .user_reg2(user_reg2));
`default_nettype wire

// File: bench/cmps_host_model.sv
// host model: drives the strap pins and three-wire serial frames
// assumes tasks are called just after a rising hclk edge
`default_nettype none
module cmps_host_model (
  // strap and serial pins
  output var logic mode_pin_level, mode_pin_float, swing_pin,
  output var logic edge_pin_level, edge_pin_float, delay_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // order: mode level, mode float, swing, edge level, edge float, delay
  task automatic straps(input logic [5:0] s);
    {mode_pin_level, mode_pin_float, swing_pin, edge_pin_level, edge_pin_float,
      delay_pin} <= s; // delay pin always driven to a definite level
  endtask
  // 160 ns serial clock, resting low between frames; n below 18 is a faulty frame
  task automatic frame(input logic [17:0] bits, input int n);
    #3 delay_pin = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      edge_pin_level = bits[i];
      #80 swing_pin = 1'b1;
      #80 swing_pin = 1'b0;
    end
    #80 delay_pin = 1'b1;
    edge_pin_level = ~edge_pin_level; // released line must not echo the last bit
  endtask
endmodule
`default_nettype wire

// File: bench/cmps_top_tb_top.sv
// self-checking bench of the strap select block over ahb-lite and straps
// assumes cmps_top, its checker and the host model are compiled first
`default_nettype none
module cmps_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0000_0000;
  wire hreadyout, hresp, mpl, mpf, swp, epl, epf, dlp;
  wire [31:0] hrdata;
  logic [31:0] exp_q[$];
  integer seed = 32'h5901_c150;
  int n_fail = 0, n_compared = 0;
  initial forever #4 hclk = ~hclk;
  cmps_host_model host (.mode_pin_level(mpl), .mode_pin_float(mpf), .swing_pin(swp),
    .edge_pin_level(epl), .edge_pin_float(epf), .delay_pin(dlp));
  cmps_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mode_pin_level(mpl),
    .mode_pin_float(mpf), .swing_pin(swp), .edge_pin_level(epl), .edge_pin_float(epf),
    .delay_pin(dlp), .output_swing_level(), .output_launch_edge(), .ddr_enable(),
    .calibration_delay_select(), .input_full_scale_range(), .serial_enable(),
    .cal_permit(), .user_reg0(), .user_reg1(), .user_reg2());
  // a read's data phase ends at this edge: compare with the oldest note
  always @(posedge hclk) begin
    if (rd_ph) begin
      n_compared++;
      if (exp_q.size() == 0 || hrdata !== exp_q[0]) begin
        n_fail++;
        $display("[ERR] %0t got %h exp %h", $time, hrdata, exp_q[0]);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    rd_ph <= hsel && hreadyout && htrans[1] && !hwrite;
  end
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for hready; a hang ends the run as a mismatch
  task automatic wait_rdy;
    int t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 20);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      test_done;
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, a};
    wait_rdy;
    {hsel, htrans} <= 3'b000;
    hwdata <= d;
    wait_rdy;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic restart(input logic [5:0] s);
    hresetn <= 1'b0;
    host.straps(s);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (12) @(posedge hclk);
  endtask
  task automatic send(input logic [1:0] a, input logic [15:0] d, input int n);
    host.frame({a, d}, n);
    repeat (12) @(posedge hclk);
  endtask
  initial begin
    logic [5:0] s;
    logic [31:0] r;
    // pin mode: every mode level, swing, edge float and delay, random edge level
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      s = {k[0], 1'b0, k[1], r[0], k[2], k[3]};
      restart(s);
      rd(12'h008, {27'h0, s[5], s[0], s[1], s[2] & !s[1], s[3]});
      rd(12'h004, 32'h0000_0011);
    end
    send(2'd1, r[15:0], 18);
    rd(12'h010, 32'h0000_0000);
    rd(12'h020, 32'h0000_0000);
    // pins moved by the frame above, but the held straps must not follow them
    rd(12'h008, {27'h0, s[5], s[0], s[1], s[2] & !s[1], s[3]});
    host.straps(6'h04);
    bus(1'b1, 12'h000, 32'h0000_0001);
    repeat (12) @(posedge hclk);
    rd(12'h008, 32'h0000_0002);
    rd(12'h004, 32'h0000_0011);
    $display("test pin mode done");
    // extended mode: calibration barred until all three user registers written
    restart(6'h11);
    rd(12'h004, 32'h0000_0021);
    send(2'd1, r[15:0], 18);
    send(2'd2, r[31:16], 18);
    send(2'd2, r[15:0], 17);
    rd(12'h004, 32'h0000_012d);
    send(2'd0, r[15:0], 18);
    rd(12'h004, 32'h0000_013f);
    rd(12'h008, {27'h0, r[4:2], r[1] & !r[2], r[0]});
    rd(12'h014, {16'h0, r[31:16]});
    send(2'd1, ~r[15:0], 18);
    bus(1'b1, 12'h010, 32'hffff_ffff);
    rd(12'h010, {16'h0, ~r[15:0]});
    repeat (2) @(posedge hclk);
    $display("test extended mode done");
    test_done;
  end
endmodule
`default_nettype wire
